// File: design/ptm_pkg.sv
// constants for the four-channel pwm timer: register indices, field positions,
// reset values and bus widths.
// assumes a single bus clock domain; register byte address is four times the index.
package ptm_pkg;

	// ************************************************************
	// bus
	// ************************************************************
	localparam int ADDR_W = 9;
	localparam int DATA_W = 32;

	// ************************************************************
	// register indices (byte address = index * 4)
	// ************************************************************
	localparam logic [6:0] IDX_CLOCK_CONFIG = 7'h60;
	localparam logic [6:0] IDX_POLARITY     = 7'h61;
	localparam logic [6:0] IDX_SCALE        = 7'h62;
	localparam logic [6:0] IDX_ENABLE       = 7'h63;
	localparam logic [6:0] IDX_COUNTER0     = 7'h64;
	localparam logic [6:0] IDX_PERIOD0      = 7'h68;
	localparam logic [6:0] IDX_DUTY0        = 7'h6C;
	localparam logic [4:0] GRP_CONTROL      = IDX_CLOCK_CONFIG[6:2];
	localparam logic [4:0] GRP_COUNTER      = IDX_COUNTER0[6:2];
	localparam logic [4:0] GRP_PERIOD       = IDX_PERIOD0[6:2];
	localparam logic [4:0] GRP_DUTY         = IDX_DUTY0[6:2];

	// ************************************************************
	// field positions and masks
	// ************************************************************
	localparam int JOIN34_BIT = 7;
	localparam int JOIN12_BIT = 6;
	localparam int CKA_LSB    = 4;
	localparam int CKB_LSB    = 0;
	localparam int CLKSEL_LSB = 4;
	localparam int POL_LSB    = 0;
	localparam logic [7:0] CONFIG_MASK = 8'hF7;

	// ************************************************************
	// reset values and divider constants
	// ************************************************************
	localparam logic [7:0] RST_ZERO      = 8'h00;
	localparam logic [7:0] RST_ONES      = 8'hFF;
	localparam logic [8:0] SCALE_ZERO_N  = 9'h100;
	localparam int         PRESC_W       = 7;

	typedef enum logic [0:0] {
		PTM_IDLE = 1'b0,
		PTM_ACK  = 1'b1
	} ptm_bus_t;

endpackage

// File: design/ptm_pwm_timer.sv
// four-channel 8-bit pwm timer with pair joining, clock a/b/s prescalers and
// double-buffered period and duty, reached over an avalon-mm slave.
// assumes avalon master holds a request until it samples waitrequest low.
`timescale 1ns/10ps
`default_nettype none

module ptm_pwm_timer (
	input  wire logic                        clk,
	input  wire logic                        nrst,
	input  wire logic [ptm_pkg::ADDR_W-1:0]  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [ptm_pkg::DATA_W-1:0]  avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic      [ptm_pkg::DATA_W-1:0]  avs_readdata,
	output logic                             avs_waitrequest,
	output logic      [3:0]                  pwm_out
);
	import ptm_pkg::*;

	// ************************************************************
	// bus slave
	// ************************************************************
	ptm_bus_t                 state;
	ptm_bus_t                 next_state;
	logic [DATA_W-1:0]        next_readdata;
	logic                     next_waitrequest;
	logic [6:0]               idx;
	logic                     aligned;
	logic                     wr_en;
	logic [7:0]               wd;
	logic [7:0]               rd_mux;
	logic [7:0]               clock_config;
	logic [7:0]               next_clock_config;
	logic [7:0]               polarity_source;
	logic [7:0]               next_polarity_source;
	logic [7:0]               scaled_clock_divisor;
	logic [7:0]               next_scaled_clock_divisor;
	logic [3:0]               channel_enable_bits;
	logic [3:0]               next_channel_enable_bits;
	wire  [7:0]               cnt_w [0:3];
	wire  [7:0]               per_buf_w [0:3];
	wire  [7:0]               dty_buf_w [0:3];
	wire  [7:0]               per_act_w [0:3];
	wire  [7:0]               dty_act_w [0:3];
	wire  [3:0]               pin_w;

	assign idx     = avs_address[ADDR_W-1:2];
	assign aligned = (avs_address[1:0] == 2'h0);
	assign wd      = avs_writedata[7:0];
	// writes land at the edge where the master sees waitrequest low
	assign wr_en   = (state == PTM_ACK) && avs_write && avs_byteenable[0] && aligned;

	always_comb begin
		rd_mux = 8'h00;
		if (aligned) begin
			case (idx[6:2])
				GRP_CONTROL: begin
					case (idx[1:0])
						2'h0: rd_mux = clock_config & CONFIG_MASK;
						2'h1: rd_mux = polarity_source;
						2'h2: rd_mux = scaled_clock_divisor;
						default: rd_mux = {4'h0, channel_enable_bits};
					endcase
				end
				GRP_COUNTER: rd_mux = cnt_w[idx[1:0]];
				GRP_PERIOD: rd_mux = per_buf_w[idx[1:0]];
				GRP_DUTY: rd_mux = dty_buf_w[idx[1:0]];
				default: rd_mux = 8'h00;
			endcase
		end
	end

	always_comb begin
		next_state = state;
		next_readdata = avs_readdata;
		case (state)
			PTM_IDLE: begin
				if (avs_read || avs_write) begin
					next_state = PTM_ACK;
					next_readdata = {24'h000000, rd_mux};
				end
			end
			PTM_ACK: next_state = PTM_IDLE;
			default: next_state = PTM_IDLE;
		endcase
		next_waitrequest = (next_state != PTM_ACK);
		next_clock_config = clock_config;
		next_polarity_source = polarity_source;
		next_scaled_clock_divisor = scaled_clock_divisor;
		next_channel_enable_bits = channel_enable_bits;
		if (wr_en && idx == IDX_CLOCK_CONFIG)
			next_clock_config = wd & CONFIG_MASK;
		if (wr_en && idx == IDX_POLARITY)
			next_polarity_source = wd;
		if (wr_en && idx == IDX_SCALE)
			next_scaled_clock_divisor = wd;
		if (wr_en && idx == IDX_ENABLE)
			next_channel_enable_bits = wd[3:0];
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= PTM_IDLE;
			avs_readdata <= 32'h00000000;
			avs_waitrequest <= 1'b1;
			clock_config <= RST_ZERO;
			polarity_source <= RST_ZERO;
			scaled_clock_divisor <= RST_ZERO;
			channel_enable_bits <= 4'h0;
		end else begin
			state <= next_state;
			avs_readdata <= next_readdata;
			avs_waitrequest <= next_waitrequest;
			clock_config <= next_clock_config;
			polarity_source <= next_polarity_source;
			scaled_clock_divisor <= next_scaled_clock_divisor;
			channel_enable_bits <= next_channel_enable_bits;
		end
	end

	// ************************************************************
	// clock a, b and s prescalers
	// ************************************************************
	logic [PRESC_W-1:0]       presc;
	logic [PRESC_W-1:0]       next_presc;
	logic [8:0]               s_cnt;
	logic [8:0]               next_s_cnt;
	logic [2:0]               mask_a;
	logic [6:0]               mask_b;
	logic [8:0]               s_n;
	logic [8:0]               s_lim;
	logic                     tick_a;
	logic                     tick_b;
	logic                     tick_s;

	always_comb begin
		mask_a = 3'((4'h1 << clock_config[CKA_LSB +: 2]) - 4'h1);
		tick_a = &(presc[2:0] | ~mask_a);
		mask_b = 7'((8'h01 << clock_config[CKB_LSB +: 3]) - 8'h01);
		tick_b = &(presc | ~mask_b);
		s_n = (scaled_clock_divisor == 8'h00) ? SCALE_ZERO_N : {1'b0, scaled_clock_divisor};
		// one s tick per 2n clock a ticks; >= guards a divisor shrunk mid-count
		s_lim = 9'({s_n, 1'b0} - 10'h001);
		tick_s = tick_a && (s_cnt >= s_lim);
		next_presc = PRESC_W'(presc + 1'b1);
		next_s_cnt = s_cnt;
		if (tick_a)
			next_s_cnt = tick_s ? 9'h000 : 9'(s_cnt + 1'b1);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			presc <= '0;
			s_cnt <= 9'h000;
		end else begin
			presc <= next_presc;
			s_cnt <= next_s_cnt;
		end
	end

	// ************************************************************
	// channel pairs
	// ************************************************************
	function automatic logic [16:0] step16(input logic [15:0] c, input logic [15:0] p);
		logic [15:0] n;
		n = 16'(c + 1'b1);
		step16 = (n >= p) ? {1'b1, 16'h0000} : {1'b0, n};
	endfunction

	function automatic logic lvl(input logic [15:0] c, input logic [15:0] p,
			input logic [15:0] d, input logic pol);
		logic raw;
		raw = (p != 16'h0000) && (d < p) && (c >= d);
		lvl = raw ^ pol;
	endfunction

	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++) begin : g_pair
			logic [7:0] cnt [0:1];
			logic [7:0] per_buf [0:1];
			logic [7:0] dty_buf [0:1];
			logic [7:0] per_act [0:1];
			logic [7:0] dty_act [0:1];
			logic [1:0] out;
			logic [7:0] next_cnt [0:1];
			logic [7:0] next_per_buf [0:1];
			logic [7:0] next_dty_buf [0:1];
			logic [7:0] next_per_act [0:1];
			logic [7:0] next_dty_act [0:1];
			logic [1:0] next_out;
			logic       join_pair;

			assign join_pair = clock_config[(gp == 0) ? JOIN12_BIT : JOIN34_BIT];

			always_comb begin
				logic [1:0]  tk;
				logic [1:0]  en;
				logic [1:0]  wr_cnt;
				logic [1:0]  restart;
				logic [1:0]  adv;
				logic [1:0]  roll;
				logic [16:0] st;
				logic [15:0] n16;
				tk = 2'h0;
				en = 2'h0;
				wr_cnt = 2'h0;
				restart = 2'h0;
				adv = 2'h0;
				roll = 2'h0;
				st = 17'h00000;
				n16 = 16'h0000;
				for (int j = 0; j < 2; j++) begin
					// pair 0 runs on clock a, pair 1 on clock b, either may take s
					tk[j] = polarity_source[CLKSEL_LSB + 2*gp + j] ? tick_s
						: ((gp == 0) ? tick_a : tick_b);
					en[j] = channel_enable_bits[2*gp + j];
					wr_cnt[j] = wr_en && (idx == 7'(IDX_COUNTER0 + 2*gp + j));
					next_per_buf[j] = (wr_en && idx == 7'(IDX_PERIOD0 + 2*gp + j))
						? wd : per_buf[j];
					next_dty_buf[j] = (wr_en && idx == 7'(IDX_DUTY0 + 2*gp + j))
						? wd : dty_buf[j];
				end
				if (join_pair) begin
					// lower channel's clock and enable drive the joined counter
					en = {2{en[1]}};
					restart = {2{|wr_cnt}};
					adv = {2{en[1] && tk[1]}};
					st = step16({cnt[0], cnt[1]}, {per_act[0], per_act[1]});
					roll = {2{adv[1] && st[16]}};
					n16 = st[15:0];
				end else begin
					restart = wr_cnt;
					for (int j = 0; j < 2; j++) begin
						adv[j] = en[j] && tk[j];
						st = step16({8'h00, cnt[j]}, {8'h00, per_act[j]});
						roll[j] = adv[j] && st[16];
						n16[8*(1-j) +: 8] = st[7:0];
					end
				end
				for (int j = 0; j < 2; j++) begin
					if (restart[j])
						next_cnt[j] = 8'h00;
					else if (adv[j])
						next_cnt[j] = n16[8*(1-j) +: 8];
					else
						next_cnt[j] = cnt[j];
					if (!en[j] || roll[j] || restart[j]) begin
						next_per_act[j] = next_per_buf[j];
						next_dty_act[j] = next_dty_buf[j];
					end else begin
						next_per_act[j] = per_act[j];
						next_dty_act[j] = dty_act[j];
					end
				end
				if (join_pair) begin
					next_out[0] = lvl({next_cnt[0], next_cnt[1]},
						{next_per_act[0], next_per_act[1]},
						{next_dty_act[0], next_dty_act[1]},
						polarity_source[POL_LSB + 2*gp]);
					next_out[1] = 1'b0;
				end else begin
					for (int j = 0; j < 2; j++)
						next_out[j] = lvl({8'h00, next_cnt[j]}, {8'h00, next_per_act[j]},
							{8'h00, next_dty_act[j]}, polarity_source[POL_LSB + 2*gp + j]);
				end
			end

			always_ff @(posedge clk or negedge nrst) begin
				if (!nrst) begin
					for (int j = 0; j < 2; j++) begin
						cnt[j] <= RST_ZERO;
						per_buf[j] <= RST_ONES;
						dty_buf[j] <= RST_ONES;
						per_act[j] <= RST_ONES;
						dty_act[j] <= RST_ONES;
					end
					out <= 2'h0;
				end else begin
					for (int j = 0; j < 2; j++) begin
						cnt[j] <= next_cnt[j];
						per_buf[j] <= next_per_buf[j];
						dty_buf[j] <= next_dty_buf[j];
						per_act[j] <= next_per_act[j];
						dty_act[j] <= next_dty_act[j];
					end
					out <= next_out;
				end
			end

			for (genvar gj = 0; gj < 2; gj++) begin : g_ch
				assign cnt_w[2*gp + gj] = cnt[gj];
				assign per_buf_w[2*gp + gj] = per_buf[gj];
				assign dty_buf_w[2*gp + gj] = dty_buf[gj];
				assign per_act_w[2*gp + gj] = per_act[gj];
				assign dty_act_w[2*gp + gj] = dty_act[gj];
				assign pin_w[2*gp + gj] = out[gj];
			end
		end
	endgenerate

	assign pwm_out = pin_w;

	// ************************************************************
	// assertions
	// ************************************************************
	logic j12;
	assign j12 = clock_config[JOIN12_BIT];

	// cycles since the last clock b tick; lets the b divider be checked looking back,
	// so a config write landing mid-count cannot trip the check
	logic [3:0] gap_b;
	logic [3:0] next_gap_b;

	always_comb begin
		next_gap_b = gap_b;
		if (tick_b)
			next_gap_b = 4'h0;
		else if (gap_b != 4'hF)
			next_gap_b = 4'(gap_b + 1'b1);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gap_b <= 4'h0;
		end else begin
			gap_b <= next_gap_b;
		end
	end

	property p_cfg_bit3;
		@(posedge clk) disable iff (!nrst)
		(state == PTM_IDLE && avs_read && aligned && idx == IDX_CLOCK_CONFIG)
			|=> (avs_readdata[3] == 1'b0 && !avs_waitrequest);
	endproperty
	a_cfg_bit3: assert property (p_cfg_bit3) else $error("config bit 3 read nonzero");

	property p_clka_div2;
		@(posedge clk) disable iff (!nrst)
		(tick_a && clock_config[CKA_LSB +: 2] == 2'h1 && !avs_write) |=> !tick_a ##1 tick_a;
	endproperty
	a_clka_div2: assert property (p_clka_div2) else $error("clock a not half rate");

	property p_clkb_div8;
		@(posedge clk) disable iff (!nrst)
		(tick_b && clock_config[CKB_LSB +: 3] == 3'h3 && $past(clock_config, 2) == clock_config
			&& $past(clock_config, 4) == clock_config && $past(clock_config, 6) == clock_config
			&& $past(clock_config, 8) == clock_config) |-> gap_b == 4'h7;
	endproperty
	a_clkb_div8: assert property (p_clkb_div8) else $error("clock b not eighth rate");

	property p_disabled_hold;
		@(posedge clk) disable iff (!nrst)
		(!channel_enable_bits[0] && !j12 && !wr_en) |=> $stable(cnt_w[0]);
	endproperty
	a_disabled_hold: assert property (p_disabled_hold) else $error("disabled counter moved");

	property p_wrap;
		@(posedge clk) disable iff (!nrst)
		(channel_enable_bits[0] && !j12 && !wr_en && tick_a && !polarity_source[CLKSEL_LSB]
			&& {1'b0, cnt_w[0]} + 9'h001 >= {1'b0, per_act_w[0]}) |=> cnt_w[0] == 8'h00;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter missed wrap at period");

	property p_buffer_hold;
		@(posedge clk) disable iff (!nrst)
		(channel_enable_bits[1] && !j12 && !wr_en
			&& {1'b0, cnt_w[1]} + 9'h001 < {1'b0, per_act_w[1]})
			|=> (per_act_w[1] == $past(per_act_w[1]) && dty_act_w[1] == $past(dty_act_w[1]));
	endproperty
	a_buffer_hold: assert property (p_buffer_hold) else $error("period took effect early");

	property p_restart;
		@(posedge clk) disable iff (!nrst)
		(wr_en && idx == IDX_COUNTER0 + 7'h2 && !clock_config[JOIN34_BIT])
			|=> (cnt_w[2] == 8'h00 && per_act_w[2] == per_buf_w[2]);
	endproperty
	a_restart: assert property (p_restart) else $error("counter write did not restart");

	property p_zero_period;
		@(posedge clk) disable iff (!nrst)
		(per_act_w[0] == 8'h00 && !j12 && !$past(j12))
			|-> pwm_out[0] == $past(polarity_source[POL_LSB]);
	endproperty
	a_zero_period: assert property (p_zero_period) else $error("zero period pin not constant");

	property p_polarity;
		@(posedge clk) disable iff (!nrst)
		// the pin flop took polarity and join mode from the cycle before
		(!j12 && !$past(j12) && per_act_w[0] != 8'h00 && dty_act_w[0] < per_act_w[0])
			|-> pwm_out[0] == ((cnt_w[0] >= dty_act_w[0]) ^ $past(polarity_source[POL_LSB]));
	endproperty
	a_polarity: assert property (p_polarity) else $error("pin level wrong for duty");

	property p_join_low_pin;
		@(posedge clk) disable iff (!nrst)
		j12 |=> !pwm_out[1];
	endproperty
	a_join_low_pin: assert property (p_join_low_pin) else $error("joined lower pin driven");

	c_wrap: cover property (@(posedge clk) disable iff (!nrst)
		channel_enable_bits[0] && cnt_w[0] != 8'h00 ##1 cnt_w[0] == 8'h00);
	c_joined_high: cover property (@(posedge clk) disable iff (!nrst) j12 && pwm_out[0]);
	c_write_ack: cover property (@(posedge clk) disable iff (!nrst) wr_en);

endmodule

`default_nettype wire

// File: tb/ptm_pin_load.sv
// passive load on the four pwm pins: counts the cycles each pin spends high.
// assumes pins are sampled on the rising bus clock edge.
`timescale 1ns/10ps
`default_nettype none
module ptm_pin_load (
	input  wire logic       clk,
	input  wire logic       clear,
	input  wire logic [3:0] pins,
	output var  int         high_cnt [4]
);
	// ************************************************************
	// high-time counters
	// ************************************************************
	// one clear restarts all windows, so pins are judged over equal spans
	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (clear)
				high_cnt[i] <= 0;
			else if (pins[i] === 1'b1)
				high_cnt[i] <= high_cnt[i] + 1;
			// an unknown level weighs more than any window, so it can never match
			else if (pins[i] !== 1'b0)
				high_cnt[i] <= high_cnt[i] + 'h10000;
		end
	end
endmodule
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the four-channel pwm timer, avalon master and pin load.
// assumes the design answers each request with one low waitrequest cycle.
`timescale 1ns/10ps
`default_nettype none
module tb;
	import ptm_pkg::*;
	logic        clk;
	logic        nrst;
	logic [8:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [3:0]  pwm_out;
	logic        clear;
	int          cnt [4];
	int          errors;
	int          n_tests;
	int          cycles;
	logic [15:0] lfsr;
	logic [31:0] q;
	int          per;
	int          duty;
	int          p;
	int          w;
	int          s;
	logic [1:0]  lo;

	ptm_pwm_timer dut (.clk(clk), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pwm_out(pwm_out));
	ptm_pin_load load (.clk(clk), .clear(clear), .pins(pwm_out), .high_cnt(cnt));

	// ************************************************************
	// model and checks
	// ************************************************************
	// w must be whole periods, so the start phase cannot bias the count
	function automatic int exp_high(int pr, int dt, bit pol, int wn);
		int h;
		if (pr == 0) h = 0;
		else if (dt == 0) h = wn;
		else if (dt >= pr) h = 0;
		else h = wn / pr * (pr - dt);
		return pol ? wn - h : h;
	endfunction

	function int rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return int'(lfsr);
	endfunction

	task automatic bad(input logic [31:0] got, input logic [31:0] exp);
		errors++;
		$display("wrong value at %0t: got %h expected %h", $time, got, exp);
	endtask

	task automatic check_reg(input logic [31:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== {24'h000000, exp}) bad(got, {24'h000000, exp});
	endtask

	task automatic check_cnt(input int got, input int exp);
		n_tests++;
		if (got !== exp) bad(got, exp);
	endtask

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ************************************************************
	// bus and pin tasks
	// ************************************************************
	task automatic xfer(input logic [6:0] i, input bit wr, input logic [7:0] d,
		input logic [3:0] be, output logic [31:0] r);
		@(posedge clk);
		avs_address    <= {i, lo};
		avs_writedata  <= {24'h000000, d};
		avs_byteenable <= be;
		avs_write      <= wr;
		avs_read       <= !wr;
		// no answer time is assumed; only the bench timeout ends a hung wait
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic wr(input logic [6:0] i, input logic [7:0] d);
		logic [31:0] r;
		xfer(i, 1'b1, d, 4'hF, r);
	endtask

	task automatic rd(input logic [6:0] i, output logic [31:0] r);
		xfer(i, 1'b0, 8'h00, 4'hF, r);
	endtask

	task automatic measure(input int ch, input int wn, input int exp);
		@(posedge clk);
		clear <= 1'b1;
		@(posedge clk);
		clear <= 1'b0;
		repeat (wn) @(posedge clk);
		@(negedge clk);
		check_cnt(cnt[ch], exp);
	endtask

	// ************************************************************
	// clock, reset, timeout
	// ************************************************************
	always #50 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 40000) begin
			errors++;
			tally_and_finish();
		end
	end

	initial begin
		clk = 1'b0; nrst = 1'b0; clear = 1'b0; lfsr = 16'h4F0B;
		avs_address = 9'h000; avs_read = 1'b0; avs_write = 1'b0;
		avs_writedata = 32'h00000000; avs_byteenable = 4'h0;
		errors = 0; n_tests = 0; cycles = 0;
		lo = 2'h0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			rd(IDX_CLOCK_CONFIG + 7'(i), q);
			check_reg(q, i < 8 ? 8'h00 : 8'hFF);
		end
		wr(IDX_CLOCK_CONFIG, 8'hFF);
		rd(IDX_CLOCK_CONFIG, q);
		check_reg(q, 8'hF7);
		rd(7'h70, q);
		check_reg(q, 8'h00);
		// unaligned read gives zero; unaligned and byteenable-0 writes are dropped
		lo = 2'h2;
		wr(IDX_SCALE, 8'h33);
		rd(IDX_SCALE, q);
		check_reg(q, 8'h00);
		lo = 2'h0;
		xfer(IDX_SCALE, 1'b1, 8'h55, 4'h0, q);
		rd(IDX_SCALE, q);
		check_reg(q, 8'h00);
		wr(IDX_CLOCK_CONFIG, 8'h00);
		$display("test registers done");
		for (int r = 0; r < 3; r++) begin
			p = rnd() % 16;
			wr(IDX_POLARITY, 8'(p));
			wr(IDX_ENABLE, 8'h0F);
			for (int c = 0; c < 4; c++) begin
				per  = (r == 0 && c == 0) ? 0 : rnd() % 256;
				duty = (r == 0 && c == 1) ? 0 : rnd() % 256;
				wr(IDX_PERIOD0 + 7'(c), 8'(per));
				wr(IDX_DUTY0 + 7'(c), 8'(duty));
				rd(IDX_PERIOD0 + 7'(c), q);
				check_reg(q, 8'(per));
				wr(IDX_COUNTER0 + 7'(c), 8'h00);
				w = (per == 0) ? 256 : 2 * per;
				measure(c, w, exp_high(per, duty, p[c], w));
			end
		end
		$display("test random channels done");
		wr(IDX_POLARITY, 8'h00);
		for (int c = 0; c < 4; c++) begin
			wr(IDX_PERIOD0 + 7'(c), 8'h04);
			wr(IDX_DUTY0 + 7'(c), 8'h01);
		end
		for (int a = 0; a < 4; a++) begin
			wr(IDX_CLOCK_CONFIG, 8'(a << CKA_LSB));
			wr(IDX_COUNTER0, 8'h00);
			measure(0, 8 << a, exp_high(4, 1, 0, 8 << a));
		end
		for (int b = 0; b < 8; b++) begin
			wr(IDX_CLOCK_CONFIG, 8'(b << CKB_LSB));
			wr(IDX_COUNTER0 + 7'd2, 8'h00);
			measure(2, 8 << b, exp_high(4, 1, 0, 8 << b));
		end
		$display("test prescalers done");
		wr(IDX_CLOCK_CONFIG, 8'h00);
		wr(IDX_PERIOD0 + 7'd1, 8'd200);
		wr(IDX_DUTY0 + 7'd1, 8'd100);
		wr(IDX_COUNTER0 + 7'd1, 8'h00);
		wr(IDX_DUTY0 + 7'd1, 8'h00);
		measure(1, 60, 0);
		repeat (200) @(posedge clk);
		measure(1, 200, exp_high(200, 0, 0, 200));
		wr(IDX_DUTY0 + 7'd1, 8'd150);
		wr(IDX_COUNTER0 + 7'd1, 8'h00);
		measure(1, 100, 0);
		wr(IDX_ENABLE, 8'h00);
		wr(IDX_COUNTER0 + 7'd1, 8'h00);
		repeat (20) @(posedge clk);
		rd(IDX_COUNTER0 + 7'd1, q);
		check_reg(q, 8'h00);
		wr(IDX_ENABLE, 8'h0F);
		$display("test buffering done");
		wr(IDX_DUTY0 + 7'd1, 8'h01);
		wr(IDX_PERIOD0 + 7'd1, 8'h04);
		wr(IDX_POLARITY, 8'hF0);
		for (int k = 0; k < 3; k++) begin
			s = (k == 2) ? 0 : 2 * k + 1;
			wr(IDX_SCALE, 8'(s));
			w = (s == 0) ? 2048 : 8 * s;
			for (int c = 0; c < 4; c += 3) begin
				wr(IDX_COUNTER0 + 7'(c), 8'h00);
				measure(c, w, exp_high(4, 1, 0, w));
			end
		end
		$display("test scaled clock done");
		wr(IDX_POLARITY, 8'h00);
		for (int j = 0; j < 4; j += 2) begin
			wr(IDX_CLOCK_CONFIG, 8'(1 << (j == 2 ? JOIN34_BIT : JOIN12_BIT)));
			wr(IDX_PERIOD0 + 7'(j), 8'h01);
			wr(IDX_PERIOD0 + 7'(j + 1), 8'h04);
			wr(IDX_DUTY0 + 7'(j), 8'h00);
			wr(IDX_DUTY0 + 7'(j + 1), 8'h82);
			wr(IDX_COUNTER0 + 7'(j + 1), 8'h00);
			measure(j, 520, exp_high(260, 130, 0, 520));
			measure(j + 1, 520, 0);
		end
		$display("test joined pairs done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
